// ---- logic/plc_top.v ----
// Lane datapath control registers with the receive steering path
//
// Overview of operation
// - Each direction has a two-bit mode field: 01 8b/10b, 10 64b/66b, 11 PMA only.
// - The transmit encoder runs while its bypass bit is 0 and is skipped at 1.
// - The receive decoder runs while its bypass bit is 0 and is skipped at 1.
// - A direction's wide-bus bit at 1 gives a 20-bit bus, at 0 a 10-bit bus.
// - The wide-bus bit is ignored while that direction runs 64b/66b.
// - A direction's bond mask bit at 1 removes the lane from the bonded group.
// - In 8b/10b mode the reorder bit at 1 reverses the bits of each symbol.
// - The swap bit at 1 swaps the two bytes of the bus when it is 20 bits wide.
// - With comma alignment on, received data is shifted so the comma is in byte 0.
// - While comma alignment is on, the byte shift used is shown in a status field.
// - The two-bit shift status reads 00 to 11 for zero to three bytes, reset 00.
`timescale 1ns/1ps
`default_nettype none
`include "plc_map.vh"

module plc_top
#(
    parameter SYM_W = 10
)
(
    input wire clk_i,
    input wire sys_rst_i,
    input wire rab_request_i,
    input wire rab_wr_rdn_i,
    input wire [15:0] rab_offset_i,
    input wire [15:0] rab_wdata_i,
    output reg rab_ready_o,
    output reg [15:0] rab_rdata_o,
    output reg rab_rdata_valid_o,
    output reg [1:0] tx_mode_o,
    output reg [1:0] rx_mode_o,
    output reg tx_line_encoder_bypass_o,
    output reg rx_line_decoder_bypass_o,
    output reg tx_wide_bus_select_o,
    output reg rx_wide_bus_select_o,
    output reg tx_bond_mask_o,
    output reg rx_bond_mask_o,
    output reg tx_bit_reorder_enable_o,
    output reg rx_bit_reorder_enable_o,
    output reg tx_symbol_swap_o,
    output reg rx_symbol_swap_o,
    output reg rx_comma_align_o,
    output reg [1:0] rx_byte_shift_o,
    input wire [4*SYM_W-1:0] rx_in_data_i,
    input wire rx_in_valid_i,
    output wire rx_in_ready_o,
    output wire [4*SYM_W-1:0] rx_out_data_o,
    output wire rx_out_valid_o,
    input wire rx_out_ready_i
);

    localparam NSYM = 4;
    localparam DW = NSYM * SYM_W;

    // ************************************************************
    // Helper functions
    // ************************************************************

    // Lowest symbol holding a comma string; bit 2 flags a hit
    function [2:0] find_comma;
        input [DW-1:0] word;
        integer i;
        reg [SYM_W-1:0] sym;
        begin
            find_comma = 3'h0;
            sym = {SYM_W{1'b0}};
            for (i = NSYM - 1; i >= 0; i = i - 1)
            begin
                sym = word[i*SYM_W +: SYM_W];
                if (sym[`PLC_COMMA_W-1:0] == `PLC_COMMA_POS ||
                    sym[`PLC_COMMA_W-1:0] == `PLC_COMMA_NEG)
                    find_comma = {1'b1, i[1:0]};
            end
        end
    endfunction

    // Bus width in force: 64b/66b overrides the wide-bus bit
    function eff_wide;
        input [1:0] mode;
        input wide_bit;
        begin
            eff_wide = wide_bit & (mode != `PLC_MODE_64B66B);
        end
    endfunction

    // ************************************************************
    // Registers
    // ************************************************************
    reg [7:0] pcs_mode_select_ff;
    reg [7:0] tx_path_control_ff;
    reg [7:0] rx_path_control_ff;
    reg [1:0] byte_shift_ff;
    wire bus_take;
    wire bus_wr;
    wire bus_rd;
    reg [15:0] nxt_rdata;

    assign bus_take = rab_request_i & rab_ready_o;
    assign bus_wr = bus_take & rab_wr_rdn_i;
    assign bus_rd = bus_take & ~rab_wr_rdn_i;

    // Ready stays high: every access completes in one cycle
    always @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            rab_ready_o <= 1'b0;
        else
            rab_ready_o <= 1'b1;
    end

    // Writes; only the documented bits can ever be set
    always @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            pcs_mode_select_ff <= `PLC_RST_MODE_SELECT;
            tx_path_control_ff <= `PLC_RST_TX_PATH;
            rx_path_control_ff <= `PLC_RST_RX_PATH;
        end
        else if (bus_wr)
        begin
            case (rab_offset_i)
                `PLC_OFS_MODE_SELECT:
                    pcs_mode_select_ff <=
                        rab_wdata_i[7:0] & `PLC_MASK_MODE_SELECT;
                `PLC_OFS_TX_PATH:
                    tx_path_control_ff <=
                        rab_wdata_i[7:0] & `PLC_MASK_TX_PATH;
                `PLC_OFS_RX_PATH:
                    rx_path_control_ff <=
                        rab_wdata_i[7:0] & `PLC_MASK_RX_PATH;
                default:
                    pcs_mode_select_ff <= pcs_mode_select_ff;
            endcase
        end
    end

    // Read mux; shift status shares the receive word's upper byte
    always @*
    begin
        case (rab_offset_i)
            `PLC_OFS_MODE_SELECT:
                nxt_rdata = {8'h00, pcs_mode_select_ff};
            `PLC_OFS_TX_PATH:
                nxt_rdata = {8'h00, tx_path_control_ff};
            `PLC_OFS_RX_PATH:
                nxt_rdata = {6'h00, byte_shift_ff, rx_path_control_ff};
            default:
                nxt_rdata = 16'h0000;
        endcase
    end

    // Read data one cycle after the request is taken
    always @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            rab_rdata_o <= 16'h0000;
            rab_rdata_valid_o <= 1'b0;
        end
        else
        begin
            rab_rdata_valid_o <= bus_rd;
            if (bus_rd)
                rab_rdata_o <= nxt_rdata;
        end
    end

    // ************************************************************
    // Control outputs to the coding sublayer
    // ************************************************************
    wire [1:0] tx_mode;
    wire [1:0] rx_mode;
    wire tx_wide;
    wire rx_wide;
    wire rx_8b10b;

    assign tx_mode = pcs_mode_select_ff[`PLC_MODE_TX_HI:`PLC_MODE_TX_LO];
    assign rx_mode = pcs_mode_select_ff[`PLC_MODE_RX_HI:`PLC_MODE_RX_LO];
    assign tx_wide = eff_wide(tx_mode,
                              tx_path_control_ff[`PLC_BIT_WIDE_BUS]);
    assign rx_wide = eff_wide(rx_mode,
                              rx_path_control_ff[`PLC_BIT_WIDE_BUS]);
    assign rx_8b10b = (rx_mode == `PLC_MODE_8B10B);

    // Registered so every output comes from a flop; one cycle of lag
    always @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            tx_mode_o <= `PLC_MODE_INVALID;
            rx_mode_o <= `PLC_MODE_INVALID;
            tx_line_encoder_bypass_o <= 1'b0;
            rx_line_decoder_bypass_o <= 1'b0;
            tx_wide_bus_select_o <= 1'b0;
            rx_wide_bus_select_o <= 1'b0;
            tx_bond_mask_o <= 1'b0;
            rx_bond_mask_o <= 1'b0;
            tx_bit_reorder_enable_o <= 1'b0;
            rx_bit_reorder_enable_o <= 1'b0;
            tx_symbol_swap_o <= 1'b0;
            rx_symbol_swap_o <= 1'b0;
            rx_comma_align_o <= 1'b0;
            rx_byte_shift_o <= `PLC_RST_BYTE_SHIFT;
        end
        else
        begin
            tx_mode_o <= tx_mode;
            rx_mode_o <= rx_mode;
            tx_line_encoder_bypass_o <=
                tx_path_control_ff[`PLC_BIT_CODER_BYPASS];
            rx_line_decoder_bypass_o <=
                rx_path_control_ff[`PLC_BIT_CODER_BYPASS];
            tx_wide_bus_select_o <= tx_wide;
            rx_wide_bus_select_o <= rx_wide;
            tx_bond_mask_o <= tx_path_control_ff[`PLC_BIT_BOND_MASK];
            rx_bond_mask_o <= rx_path_control_ff[`PLC_BIT_BOND_MASK];
            tx_bit_reorder_enable_o <= (tx_mode == `PLC_MODE_8B10B) &
                tx_path_control_ff[`PLC_BIT_REORDER];
            rx_bit_reorder_enable_o <= rx_8b10b &
                rx_path_control_ff[`PLC_BIT_REORDER];
            tx_symbol_swap_o <= tx_wide &
                tx_path_control_ff[`PLC_BIT_SYM_SWAP];
            rx_symbol_swap_o <= rx_wide &
                rx_path_control_ff[`PLC_BIT_SYM_SWAP];
            rx_comma_align_o <= rx_path_control_ff[`PLC_BIT_COMMA_ALIGN];
            // Gated by the enable itself so a stale count never outlives it
            rx_byte_shift_o <= rx_path_control_ff[`PLC_BIT_COMMA_ALIGN] ?
                byte_shift_ff : `PLC_RST_BYTE_SHIFT;
        end
    end

    // ************************************************************
    // Receive steering: reorder, swap, comma alignment
    // ************************************************************
    wire [DW-1:0] reordered;
    wire [DW-1:0] swapped;
    wire [DW-1:0] staged;
    wire [2*DW-1:0] pair;
    wire [2*DW-1:0] pair_shifted;
    wire [DW-1:0] aligned;
    wire [2:0] comma_hit;
    wire align_on;
    wire buf_ready;
    wire word_take;
    reg [DW-1:0] prev_ff;

    assign align_on = rx_path_control_ff[`PLC_BIT_COMMA_ALIGN];

    // Bit reversal inside each symbol, 8b/10b only
    genvar gs;
    genvar gb;
    generate
        for (gs = 0; gs < NSYM; gs = gs + 1)
        begin : g_sym
            for (gb = 0; gb < SYM_W; gb = gb + 1)
            begin : g_bit
                assign reordered[gs*SYM_W + gb] =
                    (rx_8b10b & rx_path_control_ff[`PLC_BIT_REORDER]) ?
                    rx_in_data_i[gs*SYM_W + SYM_W - 1 - gb] :
                    rx_in_data_i[gs*SYM_W + gb];
            end
            // Neighbour symbols trade places when swapping a 20-bit bus
            assign swapped[gs*SYM_W +: SYM_W] =
                (rx_wide & rx_path_control_ff[`PLC_BIT_SYM_SWAP]) ?
                reordered[(gs ^ 1)*SYM_W +: SYM_W] :
                reordered[gs*SYM_W +: SYM_W];
        end
    endgenerate

    // Alignment holds one word back so bytes after the comma follow it
    assign word_take = rx_in_valid_i & buf_ready;
    assign comma_hit = find_comma(swapped);
    assign pair = {swapped, prev_ff};
    assign pair_shifted = pair >> (byte_shift_ff * SYM_W);
    assign aligned = pair_shifted[DW-1:0];
    assign staged = align_on ? aligned : swapped;

    // Shift count follows the latest comma; cleared while alignment is off
    always @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            prev_ff <= {DW{1'b0}};
            byte_shift_ff <= `PLC_RST_BYTE_SHIFT;
        end
        else
        begin
            if (word_take)
                prev_ff <= swapped;
            if (!align_on)
                byte_shift_ff <= `PLC_RST_BYTE_SHIFT;
            else if (word_take && comma_hit[2])
                byte_shift_ff <= comma_hit[1:0];
        end
    end

    // Two-entry buffer; its ready stalls the source
    plc_buf
    #(
        .DW(DW)
    )
    u_buf
    (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .in_valid_i(rx_in_valid_i),
        .in_ready_o(buf_ready),
        .in_data_i(staged),
        .out_valid_o(rx_out_valid_o),
        .out_ready_i(rx_out_ready_i),
        .out_data_o(rx_out_data_o)
    );

    assign rx_in_ready_o = buf_ready;

endmodule

`default_nettype wire

// ---- logic/plc_map.vh ----
// Register map, field positions, codes and reset values of the lane control
`ifndef PLC_MAP_VH
`define PLC_MAP_VH

// Word offsets on the register access bus
`define PLC_OFS_MODE_SELECT 16'h0000
`define PLC_OFS_TX_PATH 16'h0008
`define PLC_OFS_RX_PATH 16'h0009

// Mode select fields
`define PLC_MODE_TX_LO 0
`define PLC_MODE_TX_HI 1
`define PLC_MODE_RX_LO 2
`define PLC_MODE_RX_HI 3

// Datapath mode codes
`define PLC_MODE_INVALID 2'h0
`define PLC_MODE_8B10B 2'h1
`define PLC_MODE_64B66B 2'h2
`define PLC_MODE_PMA_ONLY 2'h3

// Path control fields (same layout for both directions, comma align receive only)
`define PLC_BIT_CODER_BYPASS 0
`define PLC_BIT_WIDE_BUS 1
`define PLC_BIT_BOND_MASK 2
`define PLC_BIT_REORDER 3
`define PLC_BIT_SYM_SWAP 4
`define PLC_BIT_COMMA_ALIGN 5

// Writable bits of each register
`define PLC_MASK_MODE_SELECT 8'h0F
`define PLC_MASK_TX_PATH 8'h1F
`define PLC_MASK_RX_PATH 8'h3F

// Reset values
`define PLC_RST_MODE_SELECT 8'h00
`define PLC_RST_TX_PATH 8'h00
`define PLC_RST_RX_PATH 8'h00
`define PLC_RST_BYTE_SHIFT 2'h0

// Seven-bit comma strings, checked in the low bits of a symbol
`define PLC_COMMA_POS 7'h1F
`define PLC_COMMA_NEG 7'h60
`define PLC_COMMA_W 7

`endif

// ---- logic/plc_buf.v ----
// Two-entry buffer with valid/ready on both sides and registered outputs
`timescale 1ns/1ps
`default_nettype none

module plc_buf
#(
    parameter DW = 40
)
(
    input wire clk_i,
    input wire sys_rst_i,
    input wire in_valid_i,
    output reg in_ready_o,
    input wire [DW-1:0] in_data_i,
    output reg out_valid_o,
    input wire out_ready_i,
    output reg [DW-1:0] out_data_o
);

    // ************************************************************
    // Storage: head word drives the output, skid word catches stalls
    // ************************************************************
    reg [DW-1:0] skid_ff;
    reg skid_valid_ff;
    reg [DW-1:0] nxt_head;
    reg [DW-1:0] nxt_skid;
    reg nxt_head_valid;
    reg nxt_skid_valid;
    wire push;
    wire pop;

    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;

    // Next state; head refills from skid first so order is kept
    always @*
    begin
        nxt_head = out_data_o;
        nxt_skid = skid_ff;
        nxt_head_valid = out_valid_o;
        nxt_skid_valid = skid_valid_ff;
        if (!out_valid_o || pop)
        begin
            if (skid_valid_ff)
            begin
                nxt_head = skid_ff;
                nxt_head_valid = 1'b1;
                nxt_skid_valid = push;
                if (push)
                    nxt_skid = in_data_i;
            end
            else
            begin
                nxt_head_valid = push;
                if (push)
                    nxt_head = in_data_i;
            end
        end
        else if (push)
        begin
            nxt_skid = in_data_i;
            nxt_skid_valid = 1'b1;
        end
    end

    // Ready drops only when both entries hold data
    always @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            out_data_o <= {DW{1'b0}};
            skid_ff <= {DW{1'b0}};
            out_valid_o <= 1'b0;
            skid_valid_ff <= 1'b0;
            in_ready_o <= 1'b0;
        end
        else
        begin
            out_data_o <= nxt_head;
            skid_ff <= nxt_skid;
            out_valid_o <= nxt_head_valid;
            skid_valid_ff <= nxt_skid_valid;
            in_ready_o <= ~nxt_skid_valid;
        end
    end

endmodule

`default_nettype wire

// ---- tb/plc_top_assertions.sv ----
// Concurrent checks on the lane control register block ports
`timescale 1ns/1ps
`default_nettype none
`include "plc_map.vh"
// ****************************************
// Port checker
// ****************************************
module plc_top_chk
#(
    parameter SYM_W = 10
)
(
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic rab_request_i,
    input wire logic rab_wr_rdn_i,
    input wire logic [15:0] rab_offset_i,
    input wire logic [15:0] rab_wdata_i,
    input wire logic rab_ready_o,
    input wire logic rab_rdata_valid_o,
    input wire logic [1:0] tx_mode_o,
    input wire logic [1:0] rx_mode_o,
    input wire logic tx_line_encoder_bypass_o,
    input wire logic rx_line_decoder_bypass_o,
    input wire logic tx_wide_bus_select_o,
    input wire logic rx_wide_bus_select_o,
    input wire logic tx_bond_mask_o,
    input wire logic rx_bond_mask_o,
    input wire logic tx_bit_reorder_enable_o,
    input wire logic rx_bit_reorder_enable_o,
    input wire logic tx_symbol_swap_o,
    input wire logic rx_symbol_swap_o,
    input wire logic rx_comma_align_o,
    input wire logic [1:0] rx_byte_shift_o,
    input wire logic rx_out_valid_o,
    input wire logic rx_out_ready_i,
    input wire logic [4*SYM_W-1:0] rx_out_data_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    // Accepted bus requests, split by direction
    wire rd_go = rab_request_i && rab_ready_o && !rab_wr_rdn_i;
    wire wr_go = rab_request_i && rab_ready_o && rab_wr_rdn_i;
    a_read_valid_once: assert property (rd_go |=> rab_rdata_valid_o)
        else $error("read not answered");
    a_valid_has_cause: assert property (rab_rdata_valid_o |-> $past(rd_go))
        else $error("read data valid without a read");
    a_ready_after_rst: assert property (!rab_ready_o |-> $past(sys_rst_i))
        else $error("bus ready dropped");
    a_mode_write: assert property (
        wr_go && rab_offset_i == `PLC_OFS_MODE_SELECT |-> ##2
        {rx_mode_o, tx_mode_o} == $past(rab_wdata_i[3:0], 2))
        else $error("mode fields wrong after write");
    a_tx_path_write: assert property (
        wr_go && rab_offset_i == `PLC_OFS_TX_PATH |-> ##2
        {tx_bond_mask_o, tx_line_encoder_bypass_o} ==
        {$past(rab_wdata_i[2], 2), $past(rab_wdata_i[0], 2)})
        else $error("tx path outputs wrong after write");
    a_rx_path_write: assert property (
        wr_go && rab_offset_i == `PLC_OFS_RX_PATH |-> ##2
        {rx_comma_align_o, rx_bond_mask_o, rx_line_decoder_bypass_o} ==
        {$past(rab_wdata_i[5], 2), $past(rab_wdata_i[2], 2),
        $past(rab_wdata_i[0], 2)})
        else $error("rx path outputs wrong after write");
    a_wide_not_64b: assert property (
        (tx_wide_bus_select_o |-> tx_mode_o != `PLC_MODE_64B66B) and
        (rx_wide_bus_select_o |-> rx_mode_o != `PLC_MODE_64B66B))
        else $error("wide bus active in 64b66b mode");
    a_reorder_8b10b: assert property (
        (tx_bit_reorder_enable_o |-> tx_mode_o == `PLC_MODE_8B10B) and
        (rx_bit_reorder_enable_o |-> rx_mode_o == `PLC_MODE_8B10B))
        else $error("reorder outside 8b10b mode");
    a_swap_needs_wide: assert property (
        (tx_symbol_swap_o |-> tx_wide_bus_select_o) and
        (rx_symbol_swap_o |-> rx_wide_bus_select_o))
        else $error("swap without wide bus");
    a_shift_needs_align: assert property (
        rx_byte_shift_o != 2'h0 |-> rx_comma_align_o)
        else $error("shift shown with alignment off");
    a_out_hold_stall: assert property (rx_out_valid_o && !rx_out_ready_i
        |=> rx_out_valid_o && $stable(rx_out_data_o))
        else $error("stalled output word changed");
    c_read: cover property (rd_go ##1 rab_rdata_valid_o);
    c_shift: cover property (rx_byte_shift_o == 2'h2);
    c_stall: cover property (rx_out_valid_o && !rx_out_ready_i);
endmodule
bind plc_top plc_top_chk #(.SYM_W(SYM_W)) u_chk (.*);
`default_nettype wire

// ---- tb/plc_ctl_model.sv ----
// Behavioural register access controller facing the lane control block
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Bus controller model
// ****************************************
module plc_ctl_model
(
    input wire logic clk_i,
    input wire logic ready_i,
    input wire logic [15:0] rdata_i,
    input wire logic rdata_valid_i,
    output logic req_o,
    output logic wr_rdn_o,
    output logic [15:0] ofs_o,
    output logic [15:0] wdata_o
);
    // Idle bus at time zero
    initial
    begin
        req_o = 1'b0;
        wr_rdn_o = 1'b0;
        ofs_o = 16'h0000;
        wdata_o = 16'h0000;
    end
    // Hold request until ready is seen; released lines are inverted so
    // a target that samples them outside a request gets garbage
    task automatic issue(input logic w, input logic [15:0] o, d);
        int n;
        n = 0;
        req_o = 1'b1;
        wr_rdn_o = w;
        ofs_o = o;
        wdata_o = d;
        @(posedge clk_i);
        while (!ready_i && n < 20)
        begin
            @(posedge clk_i);
            n++;
        end
        #1;
        req_o = 1'b0;
        wr_rdn_o = ~w;
        ofs_o = ~o;
        wdata_o = ~d;
    endtask
    // Single write; one idle edge keeps the next request apart
    task automatic wr(input logic [15:0] o, d);
        issue(1'b1, o, d);
        @(posedge clk_i);
        #1;
    endtask
    // Single read, answer taken at the edge after acceptance
    task automatic rd(input logic [15:0] o, output logic [15:0] d,
        output logic v);
        issue(1'b0, o, 16'h0000);
        @(posedge clk_i);
        v = rdata_valid_i;
        d = rdata_i;
        #1;
    endtask
endmodule
`default_nettype wire

// ---- tb/test_plc_top.sv ----
// Self-checking bench for the lane control registers and receive steering
`timescale 1ns/1ps
`default_nettype none
`include "plc_map.vh"
module test_plc_top;
    logic clk_i, sys_rst_i, rab_request_i, rab_wr_rdn_i, rab_ready_o;
    logic rab_rdata_valid_o, rx_in_valid_i, rx_in_ready_o, rx_out_valid_o;
    logic rx_out_ready_i, tx_line_encoder_bypass_o, rx_line_decoder_bypass_o;
    logic tx_wide_bus_select_o, rx_wide_bus_select_o, tx_bond_mask_o;
    logic rx_bond_mask_o, tx_bit_reorder_enable_o, rx_bit_reorder_enable_o;
    logic tx_symbol_swap_o, rx_symbol_swap_o, rx_comma_align_o;
    logic [15:0] rab_offset_i, rab_wdata_i, rab_rdata_o;
    logic [1:0] tx_mode_o, rx_mode_o, rx_byte_shift_o;
    logic [39:0] rx_in_data_i, rx_out_data_o, d;
    logic [39:0] got[$];
    int error_cnt = 0;
    int cmp_count = 0;
    int k;
    bit ok;
    logic [7:0] cfg[6] = '{8'h00, 8'h05, 8'h08, 8'h12, 8'h1A, 8'h10};
    wire logic [4:0] txv = {tx_line_encoder_bypass_o, tx_wide_bus_select_o,
        tx_bond_mask_o, tx_bit_reorder_enable_o, tx_symbol_swap_o};
    wire logic [4:0] rxv = {rx_line_decoder_bypass_o, rx_wide_bus_select_o,
        rx_bond_mask_o, rx_bit_reorder_enable_o, rx_symbol_swap_o};
    plc_top dut (.*);
    plc_ctl_model ctl (.clk_i(clk_i), .ready_i(rab_ready_o),
        .rdata_i(rab_rdata_o), .rdata_valid_i(rab_rdata_valid_o),
        .req_o(rab_request_i), .wr_rdn_o(rab_wr_rdn_i),
        .ofs_o(rab_offset_i), .wdata_o(rab_wdata_i));
    // ****************************************
    // Clock, sink and watchdog
    // ****************************************
    initial
    begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    // Collect every word the block hands over
    always @(posedge clk_i)
    begin
        if (rx_out_valid_o && rx_out_ready_i)
            got.push_back(rx_out_data_o);
    end
    // Cut a hang short well beyond the expected run
    initial
    begin
        #200000;
        error_cnt++;
        results;
    end
    // ****************************************
    // Helpers
    // ****************************************
    task automatic chk(input logic [63:0] g, e);
        cmp_count++;
        if (g !== e)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic rd(input logic [15:0] o, e);
        logic [15:0] r;
        logic v;
        ctl.rd(o, r, v);
        chk(v, 1);
        chk(r, e);
    endtask
    // Control outputs lag the register by one clock
    task automatic settle;
        @(posedge clk_i);
        #1;
    endtask
    task automatic send(input logic [39:0] w, output bit a);
        int n;
        n = 0;
        rx_in_valid_i = 1'b1;
        rx_in_data_i = w;
        @(posedge clk_i);
        while (!rx_in_ready_o && n < 8)
        begin
            @(posedge clk_i);
            n++;
        end
        a = rx_in_ready_o;
        #1;
        rx_in_valid_i = 1'b0;
        rx_in_data_i = ~w;
        @(posedge clk_i);
        #1;
    endtask
    task automatic pull(output logic [39:0] q);
        int n;
        n = 0;
        while (got.size() == 0 && n < 30)
        begin
            settle;
            n++;
        end
        q = (got.size() == 0) ? 40'hX : got.pop_front();
    endtask
    // Reference steering: per-symbol reversal, then symbol pair swap
    function automatic logic [39:0] xf(input logic [39:0] w, input logic [7:0] c);
        logic [39:0] r;
        r = w;
        if (c[3])
            for (int s = 0; s < 4; s++)
                for (int b = 0; b < 10; b++)
                    r[s*10+b] = w[s*10+9-b];
        if (c[4] && c[1])
            r = {r[29:20], r[39:30], r[9:0], r[19:10]};
        return r;
    endfunction
    task automatic results;
        if (error_cnt == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        sys_rst_i = 1'b1;
        rx_in_valid_i = 1'b0;
        rx_in_data_i = 40'h0;
        rx_out_ready_i = 1'b1;
        repeat (10) @(posedge clk_i);
        #1;
        sys_rst_i = 1'b0;
        settle;
        rd(`PLC_OFS_MODE_SELECT, 16'h0000);
        rd(`PLC_OFS_TX_PATH, 16'h0000);
        rd(`PLC_OFS_RX_PATH, 16'h0000);
        ctl.wr(16'h0001, 16'hFFFF);
        rd(16'h0001, 16'h0000);
        for (int m = 1; m < 4; m++)
        begin
            ctl.wr(`PLC_OFS_MODE_SELECT, 16'(m * 5));
            settle;
            chk({tx_mode_o, rx_mode_o}, m * 5);
        end
        ctl.wr(`PLC_OFS_MODE_SELECT, 16'hFFF5);
        rd(`PLC_OFS_MODE_SELECT, 16'h0005);
        ctl.wr(`PLC_OFS_TX_PATH, 16'hFFFF);
        rd(`PLC_OFS_TX_PATH, 16'h001F);
        chk(txv, 5'h1F);
        ctl.wr(`PLC_OFS_MODE_SELECT, 16'h0006);
        settle;
        chk(txv, 5'h14);
        ctl.wr(`PLC_OFS_MODE_SELECT, 16'h0005);
        for (int i = 0; i < 6; i++)
        begin
            ctl.wr(`PLC_OFS_RX_PATH, {8'h00, cfg[i]});
            settle;
            chk(rxv, {cfg[i][0], cfg[i][1], cfg[i][2], cfg[i][3],
                cfg[i][4] & cfg[i][1]});
            send(40'h1234567A5B + i, ok);
            pull(d);
            chk(d, xf(40'h1234567A5B + i, cfg[i]));
        end
        ctl.wr(`PLC_OFS_RX_PATH, 16'h0000);
        rx_out_ready_i = 1'b0;
        k = 0;
        ok = 1'b1;
        while (ok && k < 6)
        begin
            send(40'hA500000000 + k, ok);
            if (ok)
                k++;
        end
        chk(k >= 2, 1);
        rx_out_ready_i = 1'b1;
        for (int i = 0; i < k; i++)
        begin
            pull(d);
            chk(d, 40'hA500000000 + i);
        end
        ctl.wr(`PLC_OFS_RX_PATH, 16'h0020);
        settle;
        chk(rx_comma_align_o, 1);
        send(40'h0, ok);
        send({10'h155, 10'h01F, 10'h155, 10'h155}, ok);
        send({4{10'h2AA}}, ok);
        repeat (6) settle;
        chk(got[$], {{2{10'h2AA}}, 10'h155, 10'h01F});
        chk(rx_byte_shift_o, 2);
        rd(`PLC_OFS_RX_PATH, 16'h0220);
        ctl.wr(`PLC_OFS_RX_PATH, 16'h0000);
        settle;
        chk(rx_byte_shift_o, 0);
        results;
    end
endmodule
`default_nettype wire
